/* File: mcp_pwm_gen.sv */
// Three-pair motor-control PWM generator with AHB-Lite register slave
// Overview of operation
// - One option sets all high, one all low
// - Off level equals option; active is opposite
// - Motor control disabled: pins stay high-impedance
// - Enabled: high-impedance in reset, then off-state
// - Timing values except reload rate buffered, applied only on reload
// - Reload every 1, 2, 4 or 8 periods
// - Software sets ready; transfer at next reload
// - Buffered 2-bit clock divide by 1,2,4,8
// - Edge-aligned and center-aligned counting modes
// - Converter trigger at period end, center too
// - Sense hold: always sample or hold on active
// - Reload interrupt whenever a reload occurs
// - Trip pins or comparator force outputs off
// - Software output-off forces off-state, sets no fault flag
// - Counter keeps running during fault shutdown
// - Per-source fault enables gate the interrupt
// - Fault interrupt on any enabled fault assertion
`timescale 1ns/100ps
`default_nettype none
module mcp_pwm_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic high_side_off_level_option,
  input wire logic low_side_off_level_option,
  input wire logic motor_control_enable_option,
  input wire logic trip_input_a,
  input wire logic trip_input_b,
  input wire logic overcurrent_comparator,
  output logic high_side_out_a,
  output logic high_side_out_a_oe,
  output logic high_side_out_b,
  output logic high_side_out_b_oe,
  output logic high_side_out_c,
  output logic high_side_out_c_oe,
  output logic low_side_out_a,
  output logic low_side_out_a_oe,
  output logic low_side_out_b,
  output logic low_side_out_b_oe,
  output logic low_side_out_c,
  output logic low_side_out_c_oe,
  output logic converter_trigger,
  output logic current_sense_hold,
  output logic reload_irq,
  output logic fault_irq
);
  import mcp_pkg::*;

  typedef struct packed {
    logic opt_done;
    logic off_hi;
    logic off_lo;
    logic mc_en;
    logic [2:0] flt_s1;
    logic [2:0] flt_s2;
    logic [2:0] flt_s3;
    logic [2:0] flt_lvl;
    logic ready;
    logic trig_en;
    logic sw_off;
    logic run;
    logic [1:0] div_buf;
    logic [1:0] freq;
    logic center_buf;
    mcp_count_t period_buf;
    mcp_count_t [2:0] duty_buf;
    logic [1:0] div_act;
    logic center_act;
    mcp_count_t period_act;
    mcp_count_t [2:0] duty_act;
    logic [2:0] fault_en;
    logic reload_flag;
    logic fault_flag;
    logic [5:0] sense_sel;
    logic sense_auto;
    logic sense_all;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic [2:0] pin_hi;
    logic [2:0] pin_lo;
    logic pin_oe;
    logic trig;
    logic hold;
  } mcp_state_t;

  mcp_state_t s;
  mcp_state_t next_s;
  mcp_timebase_if tb ();

  logic [2:0] fault_raw;
  logic fault_live;
  logic force_off;
  logic [2:0] duty_on;
  logic [5:0] out_on;
  logic [5:0] sel_on;
  logic wr_en;
  logic reload_clr;
  logic fault_clr;

  mcp_timebase u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .tb(tb)
  );

  // Shadow values of center, divide and period feed the time base only after a reload; run and reload frequency go straight in
  assign tb.run = s.run;
  assign tb.center = s.center_act;
  assign tb.divide = s.div_act;
  assign tb.reload_freq = s.freq;
  assign tb.period = s.period_act;

  // Trip pins are active low, comparator active high
  assign fault_raw = {overcurrent_comparator, ~trip_input_b, ~trip_input_a};
  assign fault_live = |(s.flt_lvl & s.fault_en);
  assign force_off = fault_live | s.fault_flag | s.sw_off | ~s.run;

  generate
    for (genvar i = 0; i < 3; i++) begin : g_pair
      assign duty_on[i] = tb.count < s.duty_act[i];
      assign out_on[i] = ~force_off & duty_on[i];
      assign out_on[i+3] = ~force_off & ~duty_on[i];
    end
  endgenerate

  assign sel_on = out_on & s.sense_sel;
  assign wr_en = s.dp_valid & s.dp_write;
  assign reload_clr = wr_en && s.dp_addr == OFF_STATUS && hwdata[STAT_RELOAD];
  assign fault_clr = wr_en && s.dp_addr == OFF_STATUS && hwdata[STAT_FAULT];

  always_comb begin
    next_s = s;
    // Option bits are caught once, on the first edge after reset release
    if (!s.opt_done) begin
      next_s.opt_done = 1'b1;
      next_s.off_hi = high_side_off_level_option;
      next_s.off_lo = low_side_off_level_option;
      next_s.mc_en = motor_control_enable_option;
    end
    next_s.flt_s1 = fault_raw;
    next_s.flt_s2 = s.flt_s1;
    next_s.flt_s3 = s.flt_s2;
    for (int i = 0; i < 3; i++) begin
      if (s.flt_s2[i] == s.flt_s3[i]) begin
        next_s.flt_lvl[i] = s.flt_s3[i];
      end
    end

    if (tb.reload_evt && s.ready) begin
      next_s.div_act = s.div_buf;
      next_s.center_act = s.center_buf;
      next_s.period_act = s.period_buf;
      next_s.duty_act = s.duty_buf;
      next_s.ready = 1'b0;
    end

    // Register writes land in the data phase; a ready write wins over the clear
    if (wr_en) begin
      if (s.dp_addr == OFF_CTRL_A) begin
        next_s.ready = next_s.ready | hwdata[CTRLA_READY];
        next_s.trig_en = hwdata[CTRLA_TRIG];
        next_s.sw_off = hwdata[CTRLA_OFF];
        next_s.run = hwdata[CTRLA_RUN];
      end else if (s.dp_addr == OFF_CTRL_B) begin
        next_s.div_buf = hwdata[CTRLB_DIV_LSB +: 2];
        next_s.freq = hwdata[CTRLB_FREQ_LSB +: 2];
        next_s.center_buf = hwdata[CTRLB_CENTER];
      end else if (s.dp_addr == OFF_PERIOD) begin
        next_s.period_buf = hwdata[CNT_W-1:0];
      end else if (s.dp_addr == OFF_DUTY_A) begin
        next_s.duty_buf[0] = hwdata[CNT_W-1:0];
      end else if (s.dp_addr == OFF_DUTY_B) begin
        next_s.duty_buf[1] = hwdata[CNT_W-1:0];
      end else if (s.dp_addr == OFF_DUTY_C) begin
        next_s.duty_buf[2] = hwdata[CNT_W-1:0];
      end else if (s.dp_addr == OFF_FAULT_EN) begin
        next_s.fault_en = hwdata[2:0];
      end else if (s.dp_addr == OFF_SENSE_A) begin
        next_s.sense_sel = hwdata[5:0];
      end else if (s.dp_addr == OFF_SENSE_B) begin
        next_s.sense_auto = hwdata[SENSEB_AUTO];
        next_s.sense_all = hwdata[SENSEB_ALL];
      end
    end

    // Sticky flags: write one to clear, a new event in the same cycle wins
    next_s.reload_flag = (s.reload_flag & ~reload_clr) | tb.reload_evt;
    next_s.fault_flag = (s.fault_flag & ~fault_clr) | fault_live;

    // AHB-Lite address phase
    next_s.dp_valid = 1'b0;
    if (hsel && hready && htrans[HTRANS_ACTIVE_BIT]) begin
      next_s.dp_valid = hsize == HSIZE_WORD;
      next_s.dp_write = hwrite;
      next_s.dp_addr = haddr[7:0];
      next_s.rdata = 32'h0000_0000;
      if (!hwrite && hsize == HSIZE_WORD) begin
        if (haddr[7:0] == OFF_CTRL_A) begin
          next_s.rdata = {28'h0000000, s.run, s.sw_off, s.trig_en, s.ready};
        end else if (haddr[7:0] == OFF_CTRL_B) begin
          next_s.rdata = {27'h0000000, s.center_buf, s.freq, s.div_buf};
        end else if (haddr[7:0] == OFF_PERIOD) begin
          next_s.rdata = {16'h0000, s.period_buf};
        end else if (haddr[7:0] == OFF_DUTY_A) begin
          next_s.rdata = {16'h0000, s.duty_buf[0]};
        end else if (haddr[7:0] == OFF_DUTY_B) begin
          next_s.rdata = {16'h0000, s.duty_buf[1]};
        end else if (haddr[7:0] == OFF_DUTY_C) begin
          next_s.rdata = {16'h0000, s.duty_buf[2]};
        end else if (haddr[7:0] == OFF_FAULT_EN) begin
          next_s.rdata = {29'h00000000, s.fault_en};
        end else if (haddr[7:0] == OFF_STATUS) begin
          next_s.rdata = {29'h00000000, fault_live, s.fault_flag, s.reload_flag};
        end else if (haddr[7:0] == OFF_SENSE_A) begin
          next_s.rdata = {26'h0000000, s.sense_sel};
        end else if (haddr[7:0] == OFF_SENSE_B) begin
          next_s.rdata = {30'h00000000, s.sense_all, s.sense_auto};
        end else if (haddr[7:0] == OFF_COUNT) begin
          next_s.rdata = {16'h0000, tb.count};
        end
      end
    end

    // Output pins: active level is the inverse of the off level
    for (int i = 0; i < 3; i++) begin
      next_s.pin_hi[i] = out_on[i] ? ~s.off_hi : s.off_hi;
      next_s.pin_lo[i] = out_on[i+3] ? ~s.off_lo : s.off_lo;
    end
    next_s.pin_oe = s.opt_done & s.mc_en;

    next_s.trig = s.trig_en & (tb.period_end | (s.center_act & tb.mid_point));
    if (!s.sense_auto) begin
      next_s.hold = 1'b0;
    end else if (s.sense_all) begin
      next_s.hold = (s.sense_sel != 6'h00) && (sel_on == s.sense_sel);
    end else begin
      next_s.hold = |sel_on;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.fault_en <= FAULT_EN_RST;
      s.period_buf <= PERIOD_RST;
      s.period_act <= PERIOD_RST;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign high_side_out_a = s.pin_hi[0];
  assign high_side_out_b = s.pin_hi[1];
  assign high_side_out_c = s.pin_hi[2];
  assign low_side_out_a = s.pin_lo[0];
  assign low_side_out_b = s.pin_lo[1];
  assign low_side_out_c = s.pin_lo[2];
  assign high_side_out_a_oe = s.pin_oe;
  assign high_side_out_b_oe = s.pin_oe;
  assign high_side_out_c_oe = s.pin_oe;
  assign low_side_out_a_oe = s.pin_oe;
  assign low_side_out_b_oe = s.pin_oe;
  assign low_side_out_c_oe = s.pin_oe;
  assign converter_trigger = s.trig;
  assign current_sense_hold = s.hold;
  assign reload_irq = s.reload_flag;
  assign fault_irq = s.fault_flag;
endmodule : mcp_pwm_gen
`default_nettype wire

/* File: mcp_pkg.sv */
// Shared constants and types for the motor-control PWM generator
`default_nettype none
package mcp_pkg;
  localparam int unsigned CNT_W = 16;
  typedef logic [CNT_W-1:0] mcp_count_t;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_DUTY_A = 8'h0C;
  localparam logic [7:0] OFF_DUTY_B = 8'h10;
  localparam logic [7:0] OFF_DUTY_C = 8'h14;
  localparam logic [7:0] OFF_FAULT_EN = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_SENSE_A = 8'h20;
  localparam logic [7:0] OFF_SENSE_B = 8'h24;
  localparam logic [7:0] OFF_COUNT = 8'h28;

  // Field positions
  localparam int CTRLA_READY = 0;
  localparam int CTRLA_TRIG = 1;
  localparam int CTRLA_OFF = 2;
  localparam int CTRLA_RUN = 3;
  localparam int CTRLB_DIV_LSB = 0;
  localparam int CTRLB_FREQ_LSB = 2;
  localparam int CTRLB_CENTER = 4;
  localparam int STAT_RELOAD = 0;
  localparam int STAT_FAULT = 1;
  localparam int SENSEB_AUTO = 0;
  localparam int SENSEB_ALL = 1;

  // Reset values
  localparam mcp_count_t PERIOD_RST = 16'h00FF;
  localparam logic [2:0] FAULT_EN_RST = 3'h7;

  // AHB-Lite encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : mcp_pkg
`default_nettype wire

/* File: mcp_timebase_if.sv */
// Interface between the register/output logic and the PWM time base
`timescale 1ns/100ps
`default_nettype none
interface mcp_timebase_if;
  logic run;
  logic center;
  logic [1:0] divide;
  logic [1:0] reload_freq;
  mcp_pkg::mcp_count_t period;
  mcp_pkg::mcp_count_t count;
  logic period_end;
  logic mid_point;
  logic reload_evt;
  modport ctrl (output run, output center, output divide, output reload_freq, output period,
                input count, input period_end, input mid_point, input reload_evt);
  modport gen (input run, input center, input divide, input reload_freq, input period,
               output count, output period_end, output mid_point, output reload_evt);
endinterface : mcp_timebase_if
`default_nettype wire

/* File: mcp_timebase.sv */
// PWM time base: prescaler, edge/center counter and reload event divider
`timescale 1ns/100ps
`default_nettype none
module mcp_timebase (
  input wire logic hclk,
  input wire logic hresetn,
  mcp_timebase_if.gen tb
);
  import mcp_pkg::*;

  typedef struct packed {
    logic [2:0] presc;
    mcp_count_t count;
    logic down;
    logic [2:0] per_cnt;
    logic period_end;
    logic mid_point;
    logic reload_evt;
  } mcp_tb_state_t;

  mcp_tb_state_t s;
  mcp_tb_state_t next_s;
  logic [2:0] div_max;
  logic [2:0] per_max;

  assign div_max = 3'((4'h1 << tb.divide) - 4'h1);
  assign per_max = 3'((4'h1 << tb.reload_freq) - 4'h1);

  always_comb begin
    next_s = s;
    next_s.period_end = 1'b0;
    next_s.mid_point = 1'b0;
    next_s.reload_evt = 1'b0;
    if (!tb.run) begin
      next_s.presc = 3'h0;
      next_s.count = '0;
      next_s.down = 1'b0;
      next_s.per_cnt = 3'h0;
    end else if (s.presc >= div_max) begin
      next_s.presc = 3'h0;
      if (!tb.center || tb.period == '0) begin
        if (s.count >= tb.period) begin
          next_s.count = '0;
          next_s.period_end = 1'b1;
        end else begin
          next_s.count = s.count + 1'b1;
        end
      end else if (!s.down) begin
        if (s.count >= tb.period) begin
          next_s.down = 1'b1;
          next_s.count = tb.period - 1'b1;
          next_s.mid_point = 1'b1;
        end else begin
          next_s.count = s.count + 1'b1;
        end
      end else begin
        if (s.count <= 16'h0001) begin
          next_s.count = '0;
          next_s.down = 1'b0;
          next_s.period_end = 1'b1;
        end else begin
          next_s.count = s.count - 1'b1;
        end
      end
      if (next_s.period_end) begin
        if (s.per_cnt >= per_max) begin
          next_s.per_cnt = 3'h0;
          next_s.reload_evt = 1'b1;
        end else begin
          next_s.per_cnt = s.per_cnt + 3'h1;
        end
      end
    end else begin
      next_s.presc = s.presc + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tb.count = s.count;
  assign tb.period_end = s.period_end;
  assign tb.mid_point = s.mid_point;
  assign tb.reload_evt = s.reload_evt;
endmodule : mcp_timebase
`default_nettype wire

/* File: mcp_pwm_gen_assertions.sv */
// Concurrent checks on the pin and status ports of the PWM generator
`timescale 1ns/100ps
`default_nettype none
module mcp_pwm_gen_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] hwdata,
  input wire logic trip_input_a,
  input wire logic high_side_off_level_option,
  input wire logic low_side_off_level_option,
  input wire logic motor_control_enable_option,
  input wire logic high_side_out_a,
  input wire logic high_side_out_a_oe,
  input wire logic high_side_out_b_oe,
  input wire logic high_side_out_c_oe,
  input wire logic low_side_out_a,
  input wire logic low_side_out_a_oe,
  input wire logic low_side_out_b_oe,
  input wire logic low_side_out_c_oe,
  input wire logic converter_trigger,
  input wire logic reload_irq,
  input wire logic fault_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic hi_on;
  logic lo_on;
  assign hi_on = high_side_out_a != high_side_off_level_option;
  assign lo_on = low_side_out_a != low_side_off_level_option;
  a_oe_all_equal: assert property ({high_side_out_b_oe, high_side_out_c_oe,
    low_side_out_a_oe, low_side_out_b_oe, low_side_out_c_oe} == {5{high_side_out_a_oe}})
    else $error("output enables differ");
  a_oe_when_disabled: assert property (!motor_control_enable_option |->
    !high_side_out_a_oe) else $error("pins driven while motor control is off");
  a_no_leg_overlap: assert property (high_side_out_a_oe |-> !(hi_on && lo_on))
    else $error("both switches of a leg active");
  a_fault_forces_off: assert property (high_side_out_a_oe && fault_irq && $past(fault_irq)
    |-> !hi_on && !lo_on) else $error("outputs active while faulted");
  a_trip_raises_flag: assert property (!trip_input_a [*8] |-> fault_irq)
    else $error("trip input ignored");
  a_trigger_one_cycle: assert property (converter_trigger |=> !converter_trigger)
    else $error("trigger longer than one cycle");
  a_reload_clear_cause: assert property ($fell(reload_irq) |-> $past(hwdata[0]))
    else $error("reload flag dropped without clear");
  a_fault_clear_cause: assert property ($fell(fault_irq) |-> $past(hwdata[1])
    && trip_input_a) else $error("fault flag dropped early");
  c_fault: cover property ($rose(fault_irq));
  c_reload: cover property ($rose(reload_irq));
  c_trigger: cover property (converter_trigger);
endmodule : mcp_pwm_gen_assertions
`default_nettype wire

/* File: mcp_gate_model.sv */
// Gate driver model of the three half-bridges with pulled-down gate lines
`timescale 1ns/100ps
`default_nettype none
module mcp_gate_model (
  input wire logic hclk,
  input wire logic [5:0] pin,
  input wire logic [5:0] oe,
  input wire logic [5:0] off_lvl,
  output logic [5:0] on_now,
  output logic shoot
);
  logic [5:0] gate;
  // Released pins fall to the pull-down level
  assign gate = oe & pin;
  assign on_now = oe & (gate ^ off_lvl);
  // Both switches of one leg on at once would short the supply
  always_ff @(posedge hclk) begin
    shoot <= |(on_now[2:0] & on_now[5:3]);
  end
endmodule : mcp_gate_model
`default_nettype wire

/* File: mcp_pwm_gen_tb.sv */
// Self-checking bench for the motor-control PWM generator
`timescale 1ns/100ps
`default_nettype none
module mcp_pwm_gen_tb;
  import mcp_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, men = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, flt = 0, hs, hso, ls, lso;
  logic converter_trigger, current_sense_hold, reload_irq, fault_irq, shoot;
  logic [5:0] on_now;
  int n_errors = 0, cmp_count = 0, hon, lon, trg, hld, sh = 0;
  int sm[3] = '{1, 3, 0}, se[3] = '{100, 0, 0};
  time t0, t1;
  mcp_pwm_gen i_mcp_pwm_gen (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .high_side_off_level_option(1'b1), .low_side_off_level_option(1'b0),
    .motor_control_enable_option(men), .trip_input_a(~flt[0]), .trip_input_b(~flt[1]),
    .overcurrent_comparator(flt[2]), .high_side_out_a(hs[0]), .high_side_out_a_oe(hso[0]),
    .high_side_out_b(hs[1]), .high_side_out_b_oe(hso[1]), .high_side_out_c(hs[2]),
    .high_side_out_c_oe(hso[2]), .low_side_out_a(ls[0]), .low_side_out_a_oe(lso[0]),
    .low_side_out_b(ls[1]), .low_side_out_b_oe(lso[1]), .low_side_out_c(ls[2]),
    .low_side_out_c_oe(lso[2]), .converter_trigger, .current_sense_hold, .reload_irq,
    .fault_irq);
  mcp_gate_model i_mcp_gate_model (.hclk, .pin({ls, hs}), .oe({lso, hso}),
    .off_lvl(6'h07), .on_now, .shoot);
  initial forever #4 hclk = ~hclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rd
  task automatic rst(input logic en);
    hresetn <= 1'b0; men <= en;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : rst
  task automatic upd(input logic [31:0] b);
    wr(OFF_CTRL_B, b);
    wr(OFF_CTRL_A, 32'h0000000B);
    repeat (300) @(posedge hclk);
    rd(OFF_CTRL_A, 32'h0000000A);
  endtask : upd
  // Counts over whole periods, so the phase of the window does not matter
  task automatic win(input int n);
    hon = 0; lon = 0; trg = 0; hld = 0;
    repeat (n) begin
      @(negedge hclk);
      hon += on_now[0]; trg += converter_trigger; hld += current_sense_hold; sh += shoot;
      lon += on_now[3];
    end
    @(posedge hclk);
  endtask : win
  task automatic gap(output time t);
    wr(OFF_STATUS, 32'h1);
    @(negedge hclk);
    for (int i = 0; i < 500 && reload_irq !== 1'b1; i++) @(negedge hclk);
    t = $time;
    @(posedge hclk);
  endtask : gap
  task automatic report_and_stop();
    $display("errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200us;
    n_errors++;
    report_and_stop();
  end
  initial begin
    @(posedge hclk);
    rst(1'b0);
    chk({hso, lso}, 32'h0);
    rst(1'b1);
    chk({hso, lso, hs, ls}, 32'hFF8);
    rd(OFF_PERIOD, 32'h00FF);
    rd(OFF_FAULT_EN, 32'h7);
    rd(8'h40, 32'h0);
    wr(OFF_PERIOD, 32'h9);
    wr(OFF_DUTY_A, 32'h3);
    upd(32'h0);
    win(100);
    chk(hon, 30);
    chk(trg, 10);
    chk(lon, 70);
    wr(OFF_DUTY_A, 32'h7);
    win(100);
    chk(hon, 30);
    upd(32'h0);
    win(100);
    chk(hon, 70);
    for (int f = 0; f < 4; f++) begin
      wr(OFF_CTRL_B, 32'(f << 2));
      gap(t0);
      gap(t1);
      chk(32'((t1 - t0) / 8), 32'(10 << f));
    end
    upd(32'h1);
    win(200);
    chk(hon, 140);
    chk(trg, 10);
    upd(32'h10);
    win(180);
    chk(hon, 130);
    chk(trg, 20);
    upd(32'h0);
    wr(OFF_SENSE_A, 32'h09);
    foreach (sm[i]) begin
      wr(OFF_SENSE_B, 32'(sm[i]));
      // The hold output follows the new mode one clock after the write lands
      @(posedge hclk);
      win(100);
      chk(hld, se[i]);
    end
    for (int i = 0; i < 3; i++) begin
      flt <= 3'(1 << i);
      repeat (10) @(posedge hclk);
      chk(fault_irq, 1);
      win(100);
      chk(hon, 0);
      chk(lon, 0);
      chk(trg, 10);
      flt <= 3'h0;
      win(100);
      chk(hon, 0);
      wr(OFF_STATUS, 32'h2);
      @(posedge hclk);
      win(100);
      chk(hon, 70);
      chk(fault_irq, 0);
    end
    wr(OFF_FAULT_EN, 32'h3);
    flt <= 3'h4;
    win(100);
    chk(hon, 70);
    chk(fault_irq, 0);
    flt <= 3'h0;
    // Let the comparator level leave the filter before it is enabled again
    repeat (5) @(posedge hclk);
    wr(OFF_FAULT_EN, 32'h7);
    wr(OFF_CTRL_A, 32'hE);
    @(posedge hclk);
    win(100);
    chk(hon, 0);
    chk(trg, 10);
    wr(OFF_CTRL_A, 32'hA);
    @(posedge hclk);
    win(100);
    chk(hon, 70);
    chk(sh, 0);
    report_and_stop();
  end
endmodule : mcp_pwm_gen_tb
bind mcp_pwm_gen mcp_pwm_gen_assertions i_mcp_pwm_gen_assertions (.hclk, .hresetn, .hwdata,
  .trip_input_a, .high_side_off_level_option, .low_side_off_level_option,
  .motor_control_enable_option, .high_side_out_a, .high_side_out_a_oe, .high_side_out_b_oe,
  .high_side_out_c_oe, .low_side_out_a, .low_side_out_a_oe, .low_side_out_b_oe,
  .low_side_out_c_oe, .converter_trigger, .reload_irq, .fault_irq);
`default_nettype wire
